//--- hw/cod_decoder.v
// Purpose: decode operand fields and the invert / subtract-test instruction group
// Assumes: one instruction byte per cycle when byte_valid_i is high, with its address
// Notes:   a second stage evaluates flags once operand data is supplied
//
// Behaviour
// - Object code normally source byte before destination
// - Register byte reaches 0-255 or working register
// - Bit number is three-bit field 0-7
// - Direct address spans full 16-bit space
// - Extended register operand is 12-bit address
// - Immediate is one literal byte from stream
// - Register pair addresses even locations only
// - Working registers 0-15, pairs even 0-14
// - Relative target is next address plus displacement
// - Indexed address adds signed index to base
// - Polarity operand is a single bit
// - Vector operand is one byte 0-255
// - Invert: 60 register, 61 pointer, flags
// - Subtract test sets C Z S V only
// - Prefix 1F gives borrow subtract test form
`timescale 1ns/1ns
`include "cod_defs.vh"

module cod_decoder (
  input  wire        sys_clk_i,
  input  wire        reset_i,
  input  wire        byte_valid_i,
  input  wire [7:0]  byte_i,
  input  wire [15:0] byte_addr_i,
  input  wire [7:0]  work_base_i,
  input  wire        exec_valid_i,
  input  wire [7:0]  dst_data_i,
  input  wire [7:0]  src_data_i,
  input  wire        carry_i,
  output reg         dec_valid_o,
  output reg         illegal_o,
  output reg  [1:0]  op_kind_o,
  output reg  [11:0] dst_addr_o,
  output reg         dst_indirect_o,
  output reg  [11:0] src_addr_o,
  output reg         src_indirect_o,
  output reg         src_is_literal_o,
  output reg  [7:0]  literal_byte_operand_o,
  output reg  [2:0]  fetch_bytes_o,
  output reg  [2:0]  cycles_o,
  output reg  [3:0]  flag_upd_o,
  output reg         write_back_o,
  output reg  [15:0] direct_address_operand_o,
  output reg  [11:0] wide_reg_field_o,
  output reg  [11:0] pointer_work_reg_o,
  output reg  [7:0]  reg_pair_operand_o,
  output reg  [11:0] work_pair_operand_o,
  output reg  [15:0] jump_target_o,
  output reg  [11:0] indexed_addr_o,
  output reg  [2:0]  bit_num_o,
  output reg         polarity_o,
  output reg  [7:0]  vector_o,
  output reg         res_valid_o,
  output reg  [7:0]  result_o,
  output reg  [3:0]  flags_o,
  output reg  [3:0]  flag_we_o,
  output reg         res_write_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Byte collection states
  localparam [2:0] ST_OPC  = 3'b001;
  localparam [2:0] ST_PFX  = 3'b010;
  localparam [2:0] ST_OPND = 3'b100;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         pfx_q;
  reg         pfx_d;
  reg  [7:0]  opc_q;
  reg  [7:0]  opc_d;
  reg  [7:0]  b1_q;
  reg  [7:0]  b1_d;
  reg  [1:0]  left_q;
  reg  [1:0]  left_d;
  reg  [1:0]  kind_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers, each used by more than one path

  // Operand bytes that follow a supported opcode; zero marks an unknown one
  function [1:0] opnd_count;
    input [7:0] opc;
    begin
      case (opc)
        `COD_OPC_INV_REG, `COD_OPC_INV_PTR,
        `COD_OPC_TST_WW,  `COD_OPC_TST_WP:  opnd_count = `COD_NOPND_ONE;
        `COD_OPC_TST_RR,  `COD_OPC_TST_RP,
        `COD_OPC_TST_RL,  `COD_OPC_TST_PL:  opnd_count = `COD_NOPND_TWO;
        default:                            opnd_count = 2'h0;
      endcase
    end
  endfunction

  function is_test;
    input [7:0] opc;
    begin
      is_test = (opc >= `COD_OPC_TST_WW) && (opc <= `COD_OPC_TST_PL);
    end
  endfunction

  // Eight-bit register byte to file address; escaped form picks a working register
  function [11:0] reg_addr;
    input [7:0] b;
    input [7:0] base;
    begin
      if (b[7:4] == `COD_ESC_NIBBLE) begin
        reg_addr = {base, b[3:0]};
      end else begin
        reg_addr = {4'h0, b};
      end
    end
  endfunction

  // Working register nibble to file address
  function [11:0] work_addr;
    input [3:0] n;
    input [7:0] base;
    begin
      work_addr = {base, n};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Collection sequencer
  wire [1:0] cnt_now = opnd_count(byte_i);
  wire       last    = byte_valid_i && (state_q == ST_OPND) && (left_q == `COD_NOPND_ONE);

  always @* begin
    state_d = state_q;
    pfx_d   = pfx_q;
    opc_d   = opc_q;
    b1_d    = b1_q;
    left_d  = left_q;
    if (byte_valid_i) begin
      case (state_q)
        ST_OPC: begin
          pfx_d = 1'b0;
          opc_d = byte_i;
          if (byte_i == `COD_OPC_PREFIX) begin
            pfx_d   = 1'b1;
            state_d = ST_PFX;
          end else if (cnt_now != 2'h0) begin
            left_d  = cnt_now;
            state_d = ST_OPND;
          end
        end
        ST_PFX: begin
          opc_d = byte_i;
          // Only the subtract tests take the prefix
          if (is_test(byte_i)) begin
            left_d  = cnt_now;
            state_d = ST_OPND;
          end else begin
            state_d = ST_OPC;
          end
        end
        ST_OPND: begin
          b1_d   = byte_i;
          left_d = left_q - 2'h1;
          if (left_q == `COD_NOPND_ONE) begin
            state_d = ST_OPC;
          end
        end
        default: begin
          state_d = ST_OPC;
        end
      endcase
    end
  end

  // Unknown opcode, or prefix in front of anything but a subtract test
  wire bad = byte_valid_i &&
             (((state_q == ST_OPC) && (byte_i != `COD_OPC_PREFIX) && (cnt_now == 2'h0)) ||
              ((state_q == ST_PFX) && !is_test(byte_i)));

  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_OPC;
      pfx_q   <= 1'b0;
      opc_q   <= 8'h00;
      b1_q    <= 8'h00;
      left_q  <= 2'h0;
    end else begin
      state_q <= state_d;
      pfx_q   <= pfx_d;
      opc_q   <= opc_d;
      b1_q    <= b1_d;
      left_q  <= left_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode on the final byte
  reg  [1:0]  kind_d;
  reg  [11:0] dst_d;
  reg  [11:0] src_d;
  reg         dind_d;
  reg         sind_d;
  reg         slit_d;
  reg  [2:0]  fetch_d;
  reg  [2:0]  cyc_d;

  // Bytes of a two-operand form: b1_q came first, byte_i is last
  wire [7:0]  first_b = (opnd_count(opc_q) == `COD_NOPND_TWO) ? b1_q : byte_i;
  wire [7:0]  sx_idx  = byte_i;

  always @* begin
    kind_d  = `COD_OPK_NONE;
    dst_d   = 12'h000;
    src_d   = 12'h000;
    dind_d  = 1'b0;
    sind_d  = 1'b0;
    slit_d  = 1'b0;
    fetch_d = `COD_FETCH_THREE;
    cyc_d   = `COD_CYC_THREE;
    case (opc_q)
      `COD_OPC_INV_REG, `COD_OPC_INV_PTR: begin
        kind_d  = `COD_OPK_INVERT;
        dst_d   = reg_addr(byte_i, work_base_i);
        dind_d  = (opc_q == `COD_OPC_INV_PTR);
        fetch_d = `COD_FETCH_TWO;
        cyc_d   = (opc_q == `COD_OPC_INV_PTR) ? `COD_CYC_THREE : `COD_CYC_TWO;
      end
      `COD_OPC_TST_WW, `COD_OPC_TST_WP: begin
        dst_d   = work_addr(byte_i[7:4], work_base_i);
        src_d   = work_addr(byte_i[3:0], work_base_i);
        sind_d  = (opc_q == `COD_OPC_TST_WP);
        fetch_d = `COD_FETCH_TWO;
        cyc_d   = (opc_q == `COD_OPC_TST_WP) ? `COD_CYC_FOUR : `COD_CYC_THREE;
      end
      `COD_OPC_TST_RR, `COD_OPC_TST_RP: begin
        src_d   = reg_addr(first_b, work_base_i);
        dst_d   = reg_addr(byte_i, work_base_i);
        sind_d  = (opc_q == `COD_OPC_TST_RP);
        cyc_d   = (opc_q == `COD_OPC_TST_RP) ? `COD_CYC_FOUR : `COD_CYC_THREE;
      end
      `COD_OPC_TST_RL, `COD_OPC_TST_PL: begin
        // Literal forms place the destination first
        dst_d   = reg_addr(first_b, work_base_i);
        dind_d  = (opc_q == `COD_OPC_TST_PL);
        slit_d  = 1'b1;
        cyc_d   = (opc_q == `COD_OPC_TST_PL) ? `COD_CYC_FOUR : `COD_CYC_THREE;
      end
      default: begin
        fetch_d = `COD_FETCH_THREE;
      end
    endcase
    if (is_test(opc_q)) begin
      kind_d  = pfx_q ? `COD_OPK_BSUB_TEST : `COD_OPK_SUB_TEST;
      fetch_d = fetch_d + {2'h0, pfx_q};
    end
  end

  wire [15:0] next_pc = byte_addr_i + 16'h0001;

  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dec_valid_o              <= 1'b0;
      illegal_o                <= 1'b0;
      kind_q                   <= `COD_OPK_NONE;
      op_kind_o                <= `COD_OPK_NONE;
      dst_addr_o               <= 12'h000;
      dst_indirect_o           <= 1'b0;
      src_addr_o               <= 12'h000;
      src_indirect_o           <= 1'b0;
      src_is_literal_o         <= 1'b0;
      literal_byte_operand_o   <= 8'h00;
      fetch_bytes_o            <= 3'h0;
      cycles_o                 <= 3'h0;
      flag_upd_o               <= 4'h0;
      write_back_o             <= 1'b0;
      direct_address_operand_o <= 16'h0000;
      wide_reg_field_o         <= 12'h000;
      pointer_work_reg_o       <= 12'h000;
      reg_pair_operand_o       <= 8'h00;
      work_pair_operand_o      <= 12'h000;
      jump_target_o            <= 16'h0000;
      indexed_addr_o           <= 12'h000;
      bit_num_o                <= 3'h0;
      polarity_o               <= 1'b0;
      vector_o                 <= 8'h00;
    end else begin
      dec_valid_o <= last;
      illegal_o   <= bad;
      if (last) begin
        kind_q                 <= kind_d;
        op_kind_o              <= kind_d;
        dst_addr_o             <= dst_d;
        dst_indirect_o         <= dind_d;
        src_addr_o             <= src_d;
        src_indirect_o         <= sind_d;
        src_is_literal_o       <= slit_d;
        literal_byte_operand_o <= byte_i;
        fetch_bytes_o          <= fetch_d;
        cycles_o               <= cyc_d;
        flag_upd_o             <= is_test(opc_q) ? `COD_FWE_TEST : `COD_FWE_INVERT;
        write_back_o           <= !is_test(opc_q);
        // Generic views of the trailing operand bytes for the wider decoder
        direct_address_operand_o <= {first_b, byte_i};
        wide_reg_field_o         <= {first_b[3:0], byte_i};
        pointer_work_reg_o       <= work_addr(byte_i[3:0], work_base_i);
        reg_pair_operand_o       <= {byte_i[7:1], 1'b0};
        work_pair_operand_o      <= {work_base_i, byte_i[3:1], 1'b0};
        jump_target_o            <= next_pc + {{8{byte_i[7]}}, byte_i};
        indexed_addr_o           <= reg_addr(first_b, work_base_i) +
                                    {{4{sx_idx[7]}}, sx_idx};
        bit_num_o                <= byte_i[2:0];
        polarity_o               <= byte_i[0];
        vector_o                 <= byte_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag evaluation for the last decoded instruction
  reg  [8:0] diff;
  reg  [7:0] res_d;
  reg  [3:0] fl_d;
  reg  [3:0] fwe_d;
  reg        wr_d;

  always @* begin
    diff  = 9'h000;
    res_d = 8'h00;
    fl_d  = 4'h0;
    fwe_d = 4'h0;
    wr_d  = 1'b0;
    case (kind_q)
      `COD_OPK_INVERT: begin
        res_d = ~dst_data_i;
        fl_d  = {1'b0, (res_d == 8'h00), res_d[7], 1'b0};
        fwe_d = `COD_FWE_INVERT;
        wr_d  = 1'b1;
      end
      `COD_OPK_SUB_TEST, `COD_OPK_BSUB_TEST: begin
        diff  = {1'b0, dst_data_i} - {1'b0, src_data_i} -
                {8'h00, (kind_q == `COD_OPK_BSUB_TEST) & carry_i};
        res_d = diff[7:0];
        fl_d  = {diff[8], (res_d == 8'h00), res_d[7],
                 (dst_data_i[7] != src_data_i[7]) && (res_d[7] != dst_data_i[7])};
        fwe_d = `COD_FWE_TEST;
        wr_d  = 1'b0;
      end
      default: begin
        wr_d = 1'b0;
      end
    endcase
  end

  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      res_valid_o <= 1'b0;
      result_o    <= 8'h00;
      flags_o     <= 4'h0;
      flag_we_o   <= 4'h0;
      res_write_o <= 1'b0;
    end else begin
      res_valid_o <= exec_valid_i && (kind_q != `COD_OPK_NONE);
      if (exec_valid_i) begin
        result_o    <= res_d;
        flags_o     <= fl_d;
        flag_we_o   <= fwe_d;
        res_write_o <= wr_d && (kind_q != `COD_OPK_NONE);
      end
    end
  end

endmodule

//--- hw/cod_defs.vh
// Purpose: constants for the operand and compare/complement decoder
// Assumes: byte-wide instruction stream, 12-bit register file addresses
// Notes:   definitions only
`ifndef COD_DEFS_VH
`define COD_DEFS_VH

// Opcode bytes
`define COD_OPC_PREFIX    8'h1F
`define COD_OPC_INV_REG   8'h60
`define COD_OPC_INV_PTR   8'h61
`define COD_OPC_TST_WW    8'hA2
`define COD_OPC_TST_WP    8'hA3
`define COD_OPC_TST_RR    8'hA4
`define COD_OPC_TST_RP    8'hA5
`define COD_OPC_TST_RL    8'hA6
`define COD_OPC_TST_PL    8'hA7

// Escaped working register marker in the upper nibble
`define COD_ESC_NIBBLE    4'hE

// Operation codes driven on op_kind_o
`define COD_OPK_NONE      2'h0
`define COD_OPK_INVERT    2'h1
`define COD_OPK_SUB_TEST  2'h2
`define COD_OPK_BSUB_TEST 2'h3

// Operand bytes following the opcode
`define COD_NOPND_ONE     2'h1
`define COD_NOPND_TWO     2'h2

// Fetch byte counts without prefix
`define COD_FETCH_TWO     3'h2
`define COD_FETCH_THREE   3'h3

// Instruction cycle counts
`define COD_CYC_TWO       3'h2
`define COD_CYC_THREE     3'h3
`define COD_CYC_FOUR      3'h4

// Flag write masks, order {carry, zero, sign, overflow}
`define COD_FWE_INVERT    4'h7
`define COD_FWE_TEST      4'hF

`endif

//--- tb/cod_decoder_checker.sv
// Purpose: temporal checks on the decoder outputs
// Assumes: exec_valid_i never shares a cycle with dec_valid_o
// Notes:   bound to every cod_decoder instance
`timescale 1ns/1ns
`include "cod_defs.vh"
module cod_decoder_checker (
  input wire        sys_clk_i,
  input wire        reset_i,
  input wire        exec_valid_i,
  input wire [7:0]  dst_data_i,
  input wire [7:0]  src_data_i,
  input wire        carry_i,
  input wire        dec_valid_o,
  input wire [1:0]  op_kind_o,
  input wire [2:0]  fetch_bytes_o,
  input wire [3:0]  flag_upd_o,
  input wire        write_back_o,
  input wire [7:0]  reg_pair_operand_o,
  input wire [11:0] work_pair_operand_o,
  input wire [2:0]  bit_num_o,
  input wire        polarity_o,
  input wire [7:0]  vector_o,
  input wire        res_valid_o,
  input wire [7:0]  result_o,
  input wire [3:0]  flags_o,
  input wire [3:0]  flag_we_o,
  input wire        res_write_o
);
////////////////////////////////////////
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Borrow out in bit 8; carry only counts for the prefixed form
  wire [8:0] diff = {1'b0, dst_data_i} - {1'b0, src_data_i} - {8'h00, op_kind_o[0] & carry_i};

  res_follow_a: assert property (exec_valid_i && op_kind_o != 2'h0 |=> res_valid_o)
    else $error("no result after exec");
  inv_result_a: assert property (res_valid_o && op_kind_o == `COD_OPK_INVERT |->
    result_o == ~$past(dst_data_i) && res_write_o && flag_we_o == `COD_FWE_INVERT && !flags_o[0])
    else $error("invert result wrong");
  sub_result_a: assert property (res_valid_o && op_kind_o[1] |->
    {flags_o[3], result_o} == $past(diff) && flag_we_o == `COD_FWE_TEST)
    else $error("subtract test result wrong");
  no_writeback_a: assert property (res_valid_o && op_kind_o[1] |-> !res_write_o)
    else $error("subtract test wrote back");
  zs_follow_a: assert property (res_valid_o |->
    flags_o[2] == (result_o == 8'h00) && flags_o[1] == result_o[7])
    else $error("zero or sign wrong");
  ovf_calc_a: assert property (res_valid_o && op_kind_o == `COD_OPK_SUB_TEST |->
    flags_o[0] == ($past(dst_data_i[7]) != $past(src_data_i[7]) && result_o[7] != $past(dst_data_i[7])))
    else $error("overflow wrong");
  tst_table_a: assert property (dec_valid_o && op_kind_o[1] |->
    flag_upd_o == `COD_FWE_TEST && !write_back_o && (fetch_bytes_o - {2'b0, op_kind_o[0]}) inside {3'h2, 3'h3})
    else $error("test table wrong");
  inv_table_a: assert property (dec_valid_o && op_kind_o == `COD_OPK_INVERT |->
    fetch_bytes_o == `COD_FETCH_TWO && flag_upd_o == `COD_FWE_INVERT && write_back_o)
    else $error("invert table wrong");
  pair_even_a: assert property (dec_valid_o |-> !reg_pair_operand_o[0] && !work_pair_operand_o[0])
    else $error("pair not even");
  bit_view_a: assert property (dec_valid_o |-> bit_num_o == vector_o[2:0] && polarity_o == vector_o[0])
    else $error("bit view wrong");
endmodule

bind cod_decoder cod_decoder_checker cod_decoder_checker_inst (.sys_clk_i, .reset_i, .exec_valid_i,
  .dst_data_i, .src_data_i, .carry_i, .dec_valid_o, .op_kind_o, .fetch_bytes_o, .flag_upd_o,
  .write_back_o, .reg_pair_operand_o, .work_pair_operand_o, .bit_num_o, .polarity_o, .vector_o,
  .res_valid_o, .result_o, .flags_o, .flag_we_o, .res_write_o);

//--- tb/cod_prog_mem.sv
// Purpose: program memory streaming instruction bytes
// Assumes: go_i pulses once per instruction
// Notes:   slow_i inserts an idle cycle between bytes
`timescale 1ns/1ns
module cod_prog_mem (
  input  wire        sys_clk_i,
  input  wire        reset_i,
  input  wire        go_i,
  input  wire [15:0] start_i,
  input  wire [2:0]  len_i,
  input  wire        slow_i,
  output reg         byte_valid_o,
  output reg  [7:0]  byte_o,
  output reg  [15:0] byte_addr_o
);
////////////////////////////////////////
  reg [7:0]  mem [0:255];
  reg [2:0]  left_q;
  reg [15:0] pc_q;
  reg        gap_q;
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      byte_valid_o <= 1'b0;
      byte_o <= 8'h00;
      byte_addr_o <= 16'h0000;
      left_q <= 3'h0;
      pc_q <= 16'h0000;
      gap_q <= 1'b0;
    end else begin
      byte_valid_o <= 1'b0;
      // Idle bus keeps toggling so a stale byte is never mistaken for data
      byte_o <= ~byte_o;
      if (go_i) begin
        left_q <= len_i;
        pc_q <= start_i;
        gap_q <= 1'b0;
      end else if (left_q != 3'h0 && !gap_q) begin
        byte_valid_o <= 1'b1;
        byte_o <= mem[pc_q[7:0]];
        byte_addr_o <= pc_q;
        pc_q <= pc_q + 16'h0001;
        left_q <= left_q - 3'h1;
        gap_q <= slow_i;
      end else begin
        gap_q <= 1'b0;
      end
    end
  end
endmodule

//--- tb/tb_cod_decoder.sv
// Purpose: self-checking bench for the operand decoder
// Assumes: memory model supplies the instruction bytes
// Notes:   one task per scenario
`timescale 1ns/1ns
`include "cod_defs.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_cod_decoder;
  reg         sys_clk_i = 1'b0;
  reg         reset_i = 1'b1;
  reg         go = 1'b0;
  reg         slow = 1'b0;
  reg  [15:0] start = 16'h0000;
  reg  [2:0]  len = 3'h0;
  reg         exec_valid_i = 1'b0;
  reg         carry_i = 1'b0;
  reg  [7:0]  dst_data_i = 8'h00;
  reg  [7:0]  src_data_i = 8'h00;
  reg  [7:0]  work_base_i = 8'h3C;
  wire        byte_valid_i;
  wire [7:0]  byte_i;
  wire [15:0] byte_addr_i;
  wire        dec_valid_o, illegal_o, dst_indirect_o, src_indirect_o, src_is_literal_o;
  wire        write_back_o, polarity_o, res_valid_o, res_write_o;
  wire [1:0]  op_kind_o;
  wire [2:0]  fetch_bytes_o, cycles_o, bit_num_o;
  wire [3:0]  flag_upd_o, flags_o, flag_we_o;
  wire [7:0]  literal_byte_operand_o, reg_pair_operand_o, vector_o, result_o;
  wire [11:0] dst_addr_o, src_addr_o, wide_reg_field_o, pointer_work_reg_o;
  wire [11:0] work_pair_operand_o, indexed_addr_o;
  wire [15:0] direct_address_operand_o, jump_target_o;
  integer     n_fail = 0;
  integer     comparisons = 0;

  cod_decoder cod_decoder_inst (.*);
  cod_prog_mem cod_prog_mem_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .go_i(go),
    .start_i(start), .len_i(len), .slow_i(slow), .byte_valid_o(byte_valid_i), .byte_o(byte_i),
    .byte_addr_o(byte_addr_i));
////////////////////////////////////////
  always #20 sys_clk_i = ~sys_clk_i;

  task put(input [7:0] a, input [31:0] w);
    begin
      cod_prog_mem_inst.mem[a] = w[31:24];
      cod_prog_mem_inst.mem[a + 8'h01] = w[23:16];
      cod_prog_mem_inst.mem[a + 8'h02] = w[15:8];
      cod_prog_mem_inst.mem[a + 8'h03] = w[7:0];
    end
  endtask

  task fetch_run(input [15:0] a, input [2:0] n, input s);
    integer i;
    reg     ok;
    begin
      @(posedge sys_clk_i);
      go <= 1'b1;
      start <= a;
      len <= n;
      slow <= s;
      @(posedge sys_clk_i);
      go <= 1'b0;
      ok = 1'b0;
      for (i = 0; i < 20 && !ok; i++) begin
        @(posedge sys_clk_i);
        #1;
        ok = dec_valid_o | illegal_o;
      end
      `CHK("decode_done", 1'b1, ok)
    end
  endtask

  task run_exec(input [7:0] d, input [7:0] s, input c);
    begin
      @(posedge sys_clk_i);
      exec_valid_i <= 1'b1;
      dst_data_i <= d;
      src_data_i <= s;
      carry_i <= c;
      @(posedge sys_clk_i);
      exec_valid_i <= 1'b0;
      dst_data_i <= ~d;
      #1;
    end
  endtask

  task t_reset;
    begin
      `CHK("reset_out", 4'h0, {dec_valid_o, illegal_o, res_valid_o, write_back_o})
      run_exec(8'h12, 8'h34, 1'b0);
      `CHK("no_op_result", 1'b0, res_valid_o)
    end
  endtask

  task t_invert;
    begin
      put(8'h00, {8'h60, 8'h43, 8'h61, 8'hE5});
      fetch_run(16'h0000, 3'h2, 1'b0);
      `CHK("inv_kind", {`COD_OPK_INVERT, 12'h043, `COD_CYC_TWO}, {op_kind_o, dst_addr_o, cycles_o})
      run_exec(8'h5A, 8'h00, 1'b0);
      `CHK("inv_res", {8'hA5, 3'h2, 1'b1}, {result_o, flags_o[2:0], res_write_o})
      fetch_run(16'h0002, 3'h2, 1'b0);
      `CHK("inv_ptr", {work_base_i, 4'h5, 1'b1, `COD_CYC_THREE}, {dst_addr_o, dst_indirect_o, cycles_o})
      run_exec(8'hFF, 8'h00, 1'b0);
      `CHK("inv_zero", {8'h00, 3'h4, 1'b1}, {result_o, flags_o[2:0], res_write_o})
    end
  endtask

  task t_tests;
    integer    k;
    integer    p;
    reg [15:0] ops;
    begin
      for (p = 0; p < 2; p++) begin
        for (k = 0; k < 6; k++) begin
          ops = (k < 2) ? 16'h3400 : (k < 4) ? 16'h0843 : 16'h439C;
          put(8'h40, {8'h1F, 8'hA2 + k[7:0], ops});
          fetch_run(p ? 16'h0040 : 16'h0041, ((k < 2) ? 3'h2 : 3'h3) + p[2:0], 1'b0);
          `CHK("tst_kind", p ? `COD_OPK_BSUB_TEST : `COD_OPK_SUB_TEST, op_kind_o)
          `CHK("tst_fetch", ((k < 2) ? 3'h2 : 3'h3) + p[2:0], fetch_bytes_o)
          `CHK("tst_cycles", (k % 2) ? `COD_CYC_FOUR : `COD_CYC_THREE, cycles_o)
          `CHK("tst_dst", (k < 2) ? {work_base_i, 4'h3} : 12'h043, dst_addr_o)
          `CHK("tst_ind", {k == 5, k == 1 || k == 3}, {dst_indirect_o, src_indirect_o})
          if (k < 4)
            `CHK("tst_src", (k < 2) ? {work_base_i, 4'h4} : 12'h008, src_addr_o)
          else
            `CHK("tst_imm", 9'h19C, {src_is_literal_o, literal_byte_operand_o})
          run_exec(8'h80, 8'h7F, 1'b1);
          `CHK("tst_res", p ? 9'h000 : 9'h001, {flags_o[3], result_o})
          `CHK("tst_zv", {p[0], 2'b10}, {flags_o[2], flags_o[0], res_write_o})
        end
      end
    end
  endtask

  task t_views;
    begin
      put(8'hFC, {8'h00, 8'hA4, 8'hF3, 8'h85});
      fetch_run(16'h00FD, 3'h3, 1'b1);
      `CHK("order", 24'h0F3085, {src_addr_o, dst_addr_o})
      `CHK("wide_views", {16'hF385, 12'h385, work_base_i, 4'h5}, {direct_address_operand_o, wide_reg_field_o, pointer_work_reg_o})
      `CHK("pair_views", {8'h84, work_base_i, 4'h4}, {reg_pair_operand_o, work_pair_operand_o})
      `CHK("rel_views", {16'h0085, 12'h078}, {jump_target_o, indexed_addr_o})
      `CHK("bit_views", {3'h5, 1'b1, 8'h85}, {bit_num_o, polarity_o, vector_o})
    end
  endtask

  task t_illegal;
    begin
      put(8'h80, {8'h1F, 8'h00, 8'h5E, 8'h00});
      fetch_run(16'h0080, 3'h2, 1'b0);
      `CHK("bad_prefix", 2'b10, {illegal_o, dec_valid_o})
      // Unsupported plain opcode is dropped at the opcode stage
      fetch_run(16'h0082, 3'h1, 1'b0);
      `CHK("bad_opcode", 2'b10, {illegal_o, dec_valid_o})
      fetch_run(16'h0000, 3'h2, 1'b0);
      `CHK("recover", {1'b1, `COD_OPK_INVERT}, {dec_valid_o, op_kind_o})
    end
  endtask

  task summarize;
    begin
      if (n_fail == 0 && comparisons > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // About 140 cycles of traffic (under 6 us); 100 us leaves ample margin
  initial begin
    #100000;
    n_fail++;
    summarize;
  end

  initial begin
    repeat (4) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    t_reset;
    t_invert;
    t_tests;
    t_views;
    t_illegal;
    summarize;
  end
endmodule
